// ### dv/fifo_master_model.sv
// Far side of port A: FIFO master and board interrupt sources.
// Assumes the bench asks for levels; device drive wins where enabled.
module fifo_master_model (
    input  wire       clk_i,
    input  wire [6:0] want_i,
    input  wire [6:0] dev_out_i,
    input  wire [6:0] dev_oe_n_i,
    output wire [6:0] pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] drv_r;
    // Synchronous master: levels move only after an edge
    always @(posedge clk_i) begin
        drv_r <= want_i;
    end
    assign pin_o = (dev_oe_n_i & drv_r) | (~dev_oe_n_i & dev_out_i);
endmodule // fifo_master_model

// ### dv/port_a_function_mux_checker.sv
// Port-level assertions for the port A function mux.
// Assumes one clock and a synchronous active-high reset.
module port_a_function_mux_checker (
    input wire        clk_i,
    input wire        srst_i,
    input wire        code_source_select_i,
    input wire [15:0] code_addr_i,
    input wire        code_from_ext_o,
    input wire [6:0]  port_a_pin_i,
    input wire [6:0]  port_a_pin_o,
    input wire [6:0]  port_a_pin_oe_n_o,
    input wire        ext_irq_zero_o,
    input wire        ext_irq_one_o,
    input wire        fifo_read_drive_enable_o,
    input wire [1:0]  fifo_select_o,
    input wire        packet_commit_strobe_o,
    input wire        resume_irq_o,
    input wire        osc_run_o,
    input wire        suspended_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    property p_rst;
        disable iff (1'h0) srst_i |=>
            port_a_pin_oe_n_o == 7'h7F && port_a_pin_o == 7'h00;
    endproperty
    a_rst: assert property (p_rst)
        else $error("pins not released after reset");
    // Skip the edge right after reset: inputs then are pre-release
    property p_code;
        !$past(srst_i) |-> code_from_ext_o ==
            $past(code_source_select_i || code_addr_i > 16'h1FFF);
    endproperty
    a_code: assert property (p_code)
        else $error("code source wrong");
    property p_irq0; ext_irq_zero_o |-> !$past(port_a_pin_i[0]); endproperty
    a_irq0: assert property (p_irq0)
        else $error("irq zero without low pin");
    property p_irq1; ext_irq_one_o |-> $past(port_a_pin_i[1]) == 1'h0; endproperty
    a_irq1: assert property (p_irq1)
        else $error("irq one without low pin");
    property p_rd;
        fifo_read_drive_enable_o || packet_commit_strobe_o |->
            $past(port_a_pin_oe_n_o[2]) && $past(port_a_pin_oe_n_o[6]);
    endproperty
    a_rd: assert property (p_rd)
        else $error("fifo control pin still driven");
    property p_sel;
        fifo_select_o != 2'h0 |-> fifo_select_o == $past(port_a_pin_i[5:4])
            && $past(port_a_pin_oe_n_o[5:4]) == 2'h3;
    endproperty
    a_sel: assert property (p_sel)
        else $error("fifo select wrong");
    property p_res;
        resume_irq_o |-> $past(suspended_o) && $past(port_a_pin_oe_n_o[3]);
    endproperty
    a_res: assert property (p_res)
        else $error("resume irq outside suspend");
    property p_osc;
        (osc_run_o != suspended_o) and (resume_irq_o |=> osc_run_o);
    endproperty
    a_osc: assert property (p_osc)
        else $error("oscillator state wrong");
    c_res: cover property (resume_irq_o);
    c_sel: cover property (fifo_select_o == 2'h3);
    c_irq: cover property (ext_irq_one_o);
endmodule // port_a_function_mux_checker

bind port_a_function_mux port_a_function_mux_checker u_chk (
    .clk_i, .srst_i, .code_source_select_i, .code_addr_i, .code_from_ext_o,
    .port_a_pin_i, .port_a_pin_o, .port_a_pin_oe_n_o, .ext_irq_zero_o,
    .ext_irq_one_o, .fifo_read_drive_enable_o, .fifo_select_o,
    .packet_commit_strobe_o, .resume_irq_o, .osc_run_o, .suspended_o
);

// ### dv/port_a_function_mux_tb.sv
// Self-checking bench for the port A function mux.
// Assumes byte offsets of the map header and a 200 MHz clock.
module port_a_function_mux_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'h0, srst_i = 1'h1, ref48_i = 1'h0;
    logic        code_source_select_i = 1'h0, code_from_ext_o;
    logic [15:0] code_addr_i = 16'h0;
    logic [6:0]  want = 7'h0, port_a_pin_i, port_a_pin_o, port_a_pin_oe_n_o;
    logic        clock_output_pin_o, clock_output_pin_oe_n_o, ext_irq_zero_o;
    logic        ext_irq_one_o, fifo_read_drive_enable_o, resume_irq_o;
    logic        packet_commit_strobe_o, osc_run_o, suspended_o;
    logic [1:0]  fifo_select_o, s_axi_bresp, s_axi_rresp, ph = 2'h0;
    logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready;
    logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    int          num_errors = 0, check_count = 0, n;
    int          mdl [0:8] = '{default: 0};
    port_a_function_mux dut (
        .clk_i, .srst_i, .code_source_select_i, .code_addr_i,
        .code_from_ext_o, .ref48_i, .clock_output_pin_o,
        .clock_output_pin_oe_n_o, .port_a_pin_i, .port_a_pin_o,
        .port_a_pin_oe_n_o, .ext_irq_zero_o, .ext_irq_one_o,
        .fifo_read_drive_enable_o, .fifo_select_o, .packet_commit_strobe_o,
        .resume_irq_o, .osc_run_o, .suspended_o, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );
    fifo_master_model u_far (.clk_i, .want_i(want), .dev_out_i(port_a_pin_o),
        .dev_oe_n_i(port_a_pin_oe_n_o), .pin_o(port_a_pin_i));
    always #2.5 clk_i = ~clk_i;
    // Reference at a quarter of the clock stays under half rate
    always @(posedge clk_i) begin
        ph <= ph + 2'h1;
        if (ph[0]) ref48_i <= ~ref48_i;
    end
    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        @(posedge clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge clk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        chk(s_axi_bresp, er);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        @(posedge clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge clk_i);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        chk(s_axi_rdata, ed);
        chk(s_axi_rresp, er);
    endtask
    // Model keeps what software wrote; suspend request reads back clear
    task automatic put(input logic [7:0] a, input logic [31:0] d);
        wr(a, d, 2'h0);
        mdl[a >> 2] = d & ((a == 8'h00) ? 32'hFE : 32'hFF);
    endtask
    task automatic get(input logic [7:0] a);
        rd(a, mdl[a >> 2], 2'h0);
    endtask
    task automatic end_sim;
        if (num_errors == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        logic [31:0] d;
        logic        p;
        void'($urandom(5));
        tick(10);
        srst_i <= 1'h0;
        chk(port_a_pin_oe_n_o, 7'h7F);
        chk(clock_output_pin_oe_n_o, 1'h0);
        for (int i = 0; i < 9; i++) rd(8'(i * 4), 32'h0, 2'h0);
        rd(8'h40, 32'h0, 2'h2);
        wr(8'h44, 32'hFF, 2'h2);
        for (int i = 0; i < 12; i++) begin
            code_addr_i <= (i < 4) ? 16'h1FFE + 16'(i) : 16'($urandom);
            code_source_select_i <= 1'($urandom);
            tick(3);
            chk(code_from_ext_o, code_source_select_i | (code_addr_i > 16'h1FFF));
        end
        for (int s = 0; s < 3; s++) begin
            if (s > 0) put(8'h00, 32'(s << 3));
            tick(2);
            p = clock_output_pin_o;
            n = 0;
            repeat (64) begin
                @(posedge clk_i);
                n += (clock_output_pin_o && !p);
                p = clock_output_pin_o;
            end
            chk(n >= (4 << s) - 1 && n <= (4 << s) + 1, 1'h1);
        end
        put(8'h00, 32'h02);
        tick(1);
        chk(clock_output_pin_oe_n_o, 1'h1);
        put(8'h00, 32'h00);
        get(8'h00);
        chk(clock_output_pin_oe_n_o, 1'h0);
        for (int i = 0; i < 6; i++) begin
            d = $urandom & 32'h7F;
            put(8'h14, d);
            put(8'h18, d ^ 32'h55);
            get(8'h18);
            chk(port_a_pin_o, d);
            chk(port_a_pin_oe_n_o, ~(d ^ 32'h55) & 32'h7F);
            rd(8'h20, d & (d ^ 32'h55), 2'h0);
        end
        s_axi_wstrb <= 4'h0;
        wr(8'h14, 32'hFF, 2'h0);
        s_axi_wstrb <= 4'hF;
        get(8'h14);
        put(8'h18, 32'h7F);
        want <= 7'h7F;
        put(8'h04, 32'h03);
        chk(port_a_pin_oe_n_o[1:0], 2'h3);
        for (int j = 0; j < 2; j++) begin
            for (int m = 0; m < 2; m++) begin
                put(8'h1C, 32'(m << j));
                want <= 7'h7F ^ 7'(1 << j);
                n = 0;
                repeat (8) begin
                    @(posedge clk_i);
                    n += j ? ext_irq_one_o : ext_irq_zero_o;
                end
                chk(m ? n : (j ? ext_irq_one_o : ext_irq_zero_o), 1);
                want <= 7'h7F;
                tick(4);
                chk(ext_irq_zero_o | ext_irq_one_o, 1'h0);
            end
        end
        put(8'h04, 32'h00);
        put(8'h18, 32'h7C);
        want <= 7'h7C;
        tick(4);
        chk(ext_irq_zero_o | ext_irq_one_o, 1'h0);
        put(8'h08, 32'h03);
        for (int i = 0; i < 8; i++) begin
            d = $urandom;
            put(8'h0C, d & 32'h30);
            want <= d[14:8];
            tick(4);
            chk(fifo_select_o, d[13:12]);
            chk(fifo_read_drive_enable_o, d[10] == d[4]);
            chk(packet_commit_strobe_o, d[14] == d[5]);
            chk({port_a_pin_oe_n_o[6:4], port_a_pin_oe_n_o[2]}, 4'hF);
        end
        put(8'h08, 32'h00);
        want <= 7'h30;
        tick(4);
        chk(fifo_select_o, 2'h0);
        put(8'h10, 32'h92);
        chk(port_a_pin_oe_n_o[3], 1'h0);
        put(8'h18, 32'h00);
        p = code_source_select_i | (code_addr_i > 16'h1FFF);
        for (int q = 0; q < 2; q++) begin
            put(8'h10, 32'h82 | 32'(q << 4));
            want <= q ? 7'h08 : 7'h00;
            tick(4);
            put(8'h00, 32'h01);
            tick(3);
            chk(suspended_o, 1'h0);
            rd(8'h24, 32'h24 | 32'(p) << 4, 2'h0);
            want <= q ? 7'h00 : 7'h08;
            tick(4);
            put(8'h00, 32'h01);
            tick(3);
            chk({suspended_o, osc_run_o}, 2'h2);
            rd(8'h24, 32'h08 | 32'(p) << 4, 2'h0);
            want <= q ? 7'h08 : 7'h00;
            n = 0;
            repeat (8) begin
                @(posedge clk_i);
                n += resume_irq_o;
            end
            chk({n[1:0], suspended_o}, 3'h2);
        end
        put(8'h10, 32'h90);
        tick(4);
        put(8'h00, 32'h01);
        want <= 7'h00;
        tick(4);
        chk(suspended_o, 1'h1);
        put(8'h00, 32'h01);
        tick(2);
        chk(suspended_o, 1'h0);
        put(8'h18, 32'h7F);
        srst_i <= 1'h1;
        tick(2);
        srst_i <= 1'h0;
        chk(port_a_pin_oe_n_o, 7'h7F);
        rd(8'h18, 32'h0, 2'h0);
        end_sim;
    end
    initial begin
        tick(20000);
        num_errors++;
        end_sim;
    end
endmodule // port_a_function_mux_tb

// ### src/clk_out_gen.v
// Clock output generator: divides a 48 MHz tick into 12/24/48 MHz.
// Assumes ref48_i is a clock-enable-free square wave locked to 24 MHz ref.
module clk_out_gen (
    input  wire       clk_i,
    input  wire       srst_i,
    input  wire       ref48_i,
    input  wire [1:0] speed_i,
    output wire       clk_o
);
`include "port_a_function_mux_map.vh"

    reg        ref_d_r;
    reg  [1:0] div_r;
    wire       rise = ref48_i & ~ref_d_r;

    always @(posedge clk_i) begin
        if (srst_i) begin
            ref_d_r <= 1'b0;
            div_r   <= 2'h0;
        end else begin
            ref_d_r <= ref48_i;
            if (rise)
                div_r <= div_r + 2'h1;
        end
    end

    // 48 MHz passes straight through to stay phase locked
    assign clk_o = (speed_i == `SPD_48) ? ref48_i :
                   (speed_i == `SPD_24) ? div_r[0] : div_r[1];

endmodule // clk_out_gen

// ### src/port_a_function_mux.v
// Port A pin function mux with code source select and clock output.
// Assumes AXI4-Lite master, synchronous pins and a 48 MHz reference tick.
// What this block does
// RULE1: Code up to 0x1FFF fetched internally when select low, externally high.
// RULE2: Clock output runs 12, 24 or 48 MHz; 12 MHz after reset.
// RULE3: Processor control bit 1 set floats the clock output pin.
// RULE4: Pin 0 is GPIO or active-low irq zero, by alt bit 0.
// RULE5: Irq zero edge triggered when type bit one, else level.
// RULE6: Pin 1 is GPIO or active-low irq one; type bit picks edge/level.
// RULE7: Pin 2 is GPIO or input-only FIFO read drive enable by mode.
// RULE8: FIFO read drive enable polarity from FIFO polarity bit 4.
// RULE9: Pin 3 is GPIO or resume input by resume bit 7 and OE bit 3.
// RULE10: Resume source enabled by bit 1, polarity from bit 4.
// RULE11: Resume transition in suspend restarts oscillator and interrupts processor.
// RULE12: Asserted enabled resume pin refuses entry to suspend.
// RULE13: Slave FIFO mode makes pins 4 and 5 input FIFO select bits.
// RULE14: Slave FIFO mode makes pin 6 packet end, polarity FIFO bit 5.
// RULE15: After reset all port A pins are inputs, drivers off.
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
module port_a_function_mux (
    input  wire        clk_i,
    input  wire        srst_i,
    input  wire        code_source_select_i,
    input  wire [15:0] code_addr_i,
    output reg         code_from_ext_o,
    input  wire        ref48_i,
    output wire        clock_output_pin_o,
    output wire        clock_output_pin_oe_n_o,
    input  wire [6:0]  port_a_pin_i,
    output wire [6:0]  port_a_pin_o,
    output wire [6:0]  port_a_pin_oe_n_o,
    output reg         ext_irq_zero_o,
    output reg         ext_irq_one_o,
    output reg         fifo_read_drive_enable_o,
    output reg  [1:0]  fifo_select_o,
    output reg         packet_commit_strobe_o,
    output reg         resume_irq_o,
    output wire        osc_run_o,
    output wire        suspended_o,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);
`include "port_a_function_mux_map.vh"

    localparam [15:0] INT_CODE_TOP = `CODE_INT_TOP;
    localparam [1:0]  RESP_OK      = 2'h0;
    localparam [1:0]  RESP_SLVERR  = 2'h2;

    reg  [7:0]  proc_ctrl_r;
    reg  [7:0]  alt_func_r;
    reg  [7:0]  if_mode_r;
    reg  [7:0]  fifo_pol_r;
    reg  [7:0]  resume_ctrl_r;
    reg  [7:0]  pa_out_r;
    reg  [7:0]  pa_oe_r;
    reg  [7:0]  irq_type_r;
    reg         irq0_d_r;
    reg         irq1_d_r;
    reg         resume_d_r;
    reg         suspended_r;
    reg         aw_held_r;
    reg         w_held_r;
    reg  [7:0]  aw_addr_r;
    reg  [31:0] w_data_r;
    reg  [3:0]  w_strb_r;
    reg  [31:0] rd_nxt;
    reg         rd_err_nxt;
    reg         wr_err;

    wire slave_fifo = (if_mode_r[1:0] == `IFM_SLAVE_FIFO);
    wire alt0       = alt_func_r[`AF_IRQ0];
    wire alt1       = alt_func_r[`AF_IRQ1];
    // Pin 3 leaves GPIO only while its driver is also off
    wire alt3       = resume_ctrl_r[`RC_PIN3_ALT] & ~pa_oe_r[3];
    wire resume_en  = resume_ctrl_r[`RC_ALT_EN];
    wire resume_lvl = port_a_pin_i[3] ~^ resume_ctrl_r[`RC_ALT_POL];
    wire resume_act = alt3 & resume_en & resume_lvl;

    // Output enables: alternate functions here are all input-only
    wire [6:0] alt_mask;
    assign alt_mask = {slave_fifo, slave_fifo, slave_fifo, alt3,
                       slave_fifo, alt1, alt0};           // RULE4 RULE6 RULE7 RULE9 RULE13 RULE14
    assign port_a_pin_o      = pa_out_r[6:0];
    assign port_a_pin_oe_n_o = ~(pa_oe_r[6:0] & ~alt_mask); // RULE15

    clk_out_gen u_clk_out_gen (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .ref48_i (ref48_i),
        .speed_i (proc_ctrl_r[`PC_CLK_SPD_LSB+1:`PC_CLK_SPD_LSB]),
        .clk_o   (clock_output_pin_o)                     // RULE2
    );
    assign clock_output_pin_oe_n_o = proc_ctrl_r[`PC_CLK_TRI]; // RULE3

    assign osc_run_o   = ~suspended_r;
    assign suspended_o = suspended_r;

    // Pin function logic
    always @(posedge clk_i) begin
        if (srst_i) begin
            code_from_ext_o          <= 1'b0;
            ext_irq_zero_o           <= 1'b0;
            ext_irq_one_o            <= 1'b0;
            fifo_read_drive_enable_o <= 1'b0;
            fifo_select_o            <= 2'h0;
            packet_commit_strobe_o   <= 1'b0;
            resume_irq_o             <= 1'b0;
            irq0_d_r                 <= 1'b1;
            irq1_d_r                 <= 1'b1;
            resume_d_r               <= 1'b0;
        end else begin
            code_from_ext_o <= (code_addr_i <= INT_CODE_TOP) ?
                               code_source_select_i : 1'b1; // RULE1
            irq0_d_r   <= port_a_pin_i[0];
            irq1_d_r   <= port_a_pin_i[1];
            resume_d_r <= port_a_pin_i[3];
            if (!alt0)
                ext_irq_zero_o <= 1'b0;
            else if (irq_type_r[`IT_ZERO])
                ext_irq_zero_o <= irq0_d_r & ~port_a_pin_i[0]; // RULE5
            else
                ext_irq_zero_o <= ~port_a_pin_i[0];         // RULE4 RULE5
            if (!alt1)
                ext_irq_one_o <= 1'b0;
            else if (irq_type_r[`IT_ONE])
                ext_irq_one_o <= irq1_d_r & ~port_a_pin_i[1]; // RULE6
            else
                ext_irq_one_o <= ~port_a_pin_i[1];          // RULE6
            fifo_read_drive_enable_o <= slave_fifo &
                (port_a_pin_i[2] ~^ fifo_pol_r[`FP_READ_OE]); // RULE7 RULE8
            fifo_select_o <= slave_fifo ? port_a_pin_i[5:4] : 2'h0; // RULE13
            packet_commit_strobe_o <= slave_fifo &
                (port_a_pin_i[6] ~^ fifo_pol_r[`FP_PKT_END]); // RULE14
            // Any transition counts, so either polarity wakes the core
            resume_irq_o <= suspended_r & alt3 & resume_en &
                            (resume_d_r ^ port_a_pin_i[3]); // RULE10 RULE11
        end
    end

    // AXI4-Lite write channel
    assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held_r & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    wire       aw_fire = s_axi_awvalid & s_axi_awready;
    wire       w_fire  = s_axi_wvalid & s_axi_wready;
    wire       aw_ok   = aw_held_r | aw_fire;
    wire       w_ok    = w_held_r | w_fire;
    wire       do_wr   = aw_ok & w_ok;
    wire [7:0] wa      = aw_held_r ? aw_addr_r : s_axi_awaddr;
    wire [7:0] wd      = w_held_r ? w_data_r[7:0] : s_axi_wdata[7:0];
    wire       wl      = w_held_r ? w_strb_r[0] : s_axi_wstrb[0];

    always @* begin
        case (wa)
            `OFS_PROC_CTRL, `OFS_ALT_FUNC, `OFS_IF_MODE, `OFS_FIFO_POL,
            `OFS_RESUME_CTRL, `OFS_PA_OUT, `OFS_PA_OE, `OFS_IRQ_TYPE:
                wr_err = 1'b0;
            default:
                wr_err = 1'b1;
        endcase
    end

    always @(posedge clk_i) begin
        if (srst_i) begin
            proc_ctrl_r   <= `RST_PROC_CTRL;
            alt_func_r    <= `RST_ZERO8;
            if_mode_r     <= `RST_ZERO8;
            fifo_pol_r    <= `RST_ZERO8;
            resume_ctrl_r <= `RST_ZERO8;
            pa_out_r      <= `RST_ZERO8;
            pa_oe_r       <= `RST_PA_OE;                    // RULE15
            irq_type_r    <= `RST_ZERO8;
            aw_held_r     <= 1'b0;
            w_held_r      <= 1'b0;
            aw_addr_r     <= 8'h00;
            w_data_r      <= 32'h0000_0000;
            w_strb_r      <= 4'h0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OK;
            suspended_r   <= 1'b0;
        end else begin
            if (aw_fire) begin
                aw_addr_r <= s_axi_awaddr;
                aw_held_r <= 1'b1;
            end
            if (w_fire) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                w_held_r <= 1'b1;
            end
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            // Suspend request is self-clearing; wake-up ends it
            if (suspended_r && (resume_irq_o || proc_ctrl_r[`PC_SUSPEND]))
                suspended_r <= 1'b0;                        // RULE11
            proc_ctrl_r[`PC_SUSPEND] <= 1'b0;
            if (proc_ctrl_r[`PC_SUSPEND] && !suspended_r && !resume_act)
                suspended_r <= 1'b1;                        // RULE12
            if (do_wr) begin
                aw_held_r    <= 1'b0;
                w_held_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_err ? RESP_SLVERR : RESP_OK;
                if (wl) begin
                    case (wa)
                        `OFS_PROC_CTRL:   proc_ctrl_r   <= wd;
                        `OFS_ALT_FUNC:    alt_func_r    <= wd;
                        `OFS_IF_MODE:     if_mode_r     <= wd;
                        `OFS_FIFO_POL:    fifo_pol_r    <= wd;
                        `OFS_RESUME_CTRL: resume_ctrl_r <= wd;
                        `OFS_PA_OUT:      pa_out_r      <= wd;
                        `OFS_PA_OE:       pa_oe_r       <= wd;
                        `OFS_IRQ_TYPE:    irq_type_r    <= wd;
                        default:          ;
                    endcase
                end
            end
        end
    end

    // AXI4-Lite read channel
    always @* begin
        rd_nxt     = 32'h0000_0000;
        rd_err_nxt = 1'b0;
        case (s_axi_araddr)
            `OFS_PROC_CTRL:   rd_nxt[7:0] = proc_ctrl_r;
            `OFS_ALT_FUNC:    rd_nxt[7:0] = alt_func_r;
            `OFS_IF_MODE:     rd_nxt[7:0] = if_mode_r;
            `OFS_FIFO_POL:    rd_nxt[7:0] = fifo_pol_r;
            `OFS_RESUME_CTRL: rd_nxt[7:0] = resume_ctrl_r;
            `OFS_PA_OUT:      rd_nxt[7:0] = pa_out_r;
            `OFS_PA_OE:       rd_nxt[7:0] = pa_oe_r;
            `OFS_IRQ_TYPE:    rd_nxt[7:0] = irq_type_r;
            `OFS_PA_PINS:     rd_nxt[6:0] = port_a_pin_i;
            `OFS_STATUS: begin
                rd_nxt[`ST_IRQ0]      = ext_irq_zero_o;
                rd_nxt[`ST_IRQ1]      = ext_irq_one_o;
                rd_nxt[`ST_RESUME]    = resume_act;
                rd_nxt[`ST_SUSPENDED] = suspended_r;
                rd_nxt[`ST_CODE_EXT]  = code_from_ext_o;
                rd_nxt[`ST_OSC_RUN]   = ~suspended_r;
            end
            default:          rd_err_nxt = 1'b1;
        endcase
    end

    always @(posedge clk_i) begin
        if (srst_i) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OK;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_nxt;
            s_axi_rresp  <= rd_err_nxt ? RESP_SLVERR : RESP_OK;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // port_a_function_mux

// ### src/port_a_function_mux_map.vh
// Register offsets, field positions and reset values of the port A mux.
// Assumes a 32-bit AXI4-Lite slave with one aligned word per register.
`ifndef PORT_A_FUNCTION_MUX_MAP_VH
`define PORT_A_FUNCTION_MUX_MAP_VH

// Byte offsets
`define OFS_PROC_CTRL      8'h00
`define OFS_ALT_FUNC       8'h04
`define OFS_IF_MODE        8'h08
`define OFS_FIFO_POL       8'h0C
`define OFS_RESUME_CTRL    8'h10
`define OFS_PA_OUT         8'h14
`define OFS_PA_OE          8'h18
`define OFS_IRQ_TYPE       8'h1C
`define OFS_PA_PINS        8'h20
`define OFS_STATUS         8'h24

// Highest code address that the select strap can steer
`define CODE_INT_TOP       16'h1FFF

// Processor control fields
`define PC_CLK_SPD_LSB     3
`define PC_CLK_TRI         1
`define PC_SUSPEND         0
// Alternate function fields
`define AF_IRQ0            0
`define AF_IRQ1            1
// Interface mode encoding
`define IFM_SLAVE_FIFO     2'h3
// FIFO polarity fields
`define FP_READ_OE         4
`define FP_PKT_END         5
// Resume control fields
`define RC_ALT_EN          1
`define RC_ALT_POL         4
`define RC_PIN3_ALT        7
// Irq trigger type fields
`define IT_ZERO            0
`define IT_ONE             1
// Status fields
`define ST_IRQ0            0
`define ST_IRQ1            1
`define ST_RESUME          2
`define ST_SUSPENDED       3
`define ST_CODE_EXT        4
`define ST_OSC_RUN         5

// Clock speed codes
`define SPD_12             2'h0
`define SPD_24             2'h1
`define SPD_48             2'h2

// Reset values
`define RST_PROC_CTRL      8'h00
`define RST_ZERO8          8'h00
`define RST_PA_OE          8'h00

// Clock output half periods less one, in cycles of the 48 MHz reference tick
`define HALF_12            3'h1
`define HALF_24            3'h0

`endif
